// [rsd_panel_model.sv]
// Operator panel and watchdog pins facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module rsd_panel_model
  import rsd_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Requests from the bench
  input  wire logic        req_comm,
  input  wire logic        req_ctrl,
  input  wire logic        req_sw,
  // Sequencer side
  input  wire logic [31:0] disp_text,
  input  wire logic        disp_blank,
  output logic             comm_wdt,
  output logic             ctrl_wdt,
  output logic             ovr_sw,
  output logic [31:0]      shown,
  output logic [15:0]      changes
);
  logic [31:0] last;
  // Pins move only at a clock edge; the sequencer resyncs them anyway
  always @(posedge aclk) begin
    if (!aresetn) begin
      comm_wdt <= 1'b0;
      ctrl_wdt <= 1'b0;
      ovr_sw   <= 1'b0;
    end else begin
      comm_wdt <= req_comm;
      ctrl_wdt <= req_ctrl;
      ovr_sw   <= req_sw;
    end
  end
  // Glass shows blank while hardware blanking is in force
  assign shown = disp_blank ? RSD_TXT_BLANK : disp_text;
  // Counting changes is how blinking or hidden steps are caught
  always @(posedge aclk) begin
    last <= shown;
    if (!aresetn) begin
      changes <= 16'h0000;
    end else if (shown !== last) begin
      changes <= changes + 16'h0001;
    end
  end
endmodule : rsd_panel_model
`default_nettype wire

// [rsd_pkg.sv]
// Constants and types for the redundant status display sequencer
// Function
// - On a swap command the primary shows the swap banner while going secondary.
// - A secondary becoming primary shows the run banner at once.
// - Detailed swap shows each restart step code in order, then sync, then backup.
// - Non-detailed swap holds the swap banner over the steps, then sync, backup.
// - Primary shows run banner with node; backup shows backup banner with node.
// - On failover the primary fails and the secondary takes over as primary.
// - Detailed fail cycles fail, comms flag, comms code, control flag, code, blank.
// - Comms code 0010 is local RAM parity; control code FFF3 is comms no response.
// - Non-detailed fail alternates fail banner and blank, blinking continuously.
// - Only the comms processor writes and maintains the display contents; the control watchdog pin also writes the control code and forces failure.
// - Hardware blanks the display whenever the comms watchdog times out.
// - Holding the detailed-display switch overrides the watchdog blanking.
// - Control watchdog expiry never blanks; it is reported as failure info.
// - The non-detailed failure display blinks at a half-second rate.
// - The run banner is steady and never blinks.
package rsd_pkg;
  localparam int          RSD_ADDR_W   = 8;
  localparam logic [7:0]  RSD_OFF_CFG  = 8'h00;
  localparam logic [7:0]  RSD_OFF_CMD  = 8'h04;
  localparam logic [7:0]  RSD_OFF_CODE = 8'h08;
  localparam logic [7:0]  RSD_OFF_STAT = 8'h0c;
  localparam logic [7:0]  RSD_OFF_DISP = 8'h10;
  localparam logic [7:0]  RSD_OFF_IST  = 8'h14;
  localparam logic [7:0]  RSD_OFF_IEN  = 8'h18;
  localparam logic [7:0]  RSD_OFF_ICLR = 8'h1c;
  localparam int          RSD_CMD_SWAP = 0;
  localparam int          RSD_CMD_FAIL = 1;
  localparam int          RSD_CMD_TAKE = 2;
  localparam logic [15:0] RSD_COMM_RAM_PAR = 16'h0010;
  localparam logic [15:0] RSD_CTRL_NO_COMM = 16'hfff3;
  localparam logic [15:0] RSD_CTRL_WDT     = 16'hfff4;
  localparam logic [31:0] RSD_TXT_SWAP  = 32'h53574150;
  localparam logic [31:0] RSD_TXT_SYNC  = 32'h53594e43;
  localparam logic [31:0] RSD_TXT_COMM  = 32'h434f4d4d;
  localparam logic [31:0] RSD_TXT_CTRL  = 32'h4354524c;
  localparam logic [31:0] RSD_TXT_BLANK = 32'h20202020;
  localparam logic [15:0] RSD_TXT_OK    = 16'h4f4b;
  localparam logic [15:0] RSD_TXT_BK    = 16'h4220;
  localparam logic [15:0] RSD_TXT_TS    = 16'h5420;
  localparam logic [7:0]  RSD_TXT_F     = 8'h46;
  localparam logic [3:0]  RSD_STEP_LAST = 4'hc;
  localparam logic [2:0]  RSD_FAIL_LAST = 3'h5;
  localparam int          RSD_CLK_NS    = 5;
  localparam int          RSD_BLINK_NS  = 500_000_000;
  localparam int          RSD_DWELL_NS  = 500_000_000;
  localparam logic [26:0] RSD_BLINK_CYC = 27'(RSD_BLINK_NS / RSD_CLK_NS);
  localparam logic [26:0] RSD_DWELL_CYC = 27'(RSD_DWELL_NS / RSD_CLK_NS);
  typedef enum logic [2:0] {
    RSD_BACKUP = 3'b000,
    RSD_RUN    = 3'b001,
    RSD_SWAP   = 3'b010,
    RSD_STEP   = 3'b011,
    RSD_SYNC   = 3'b100,
    RSD_FAIL   = 3'b101
  } rsd_state_t;
endpackage : rsd_pkg

// [rsd_sequencer.sv]
// Status display sequencer with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module rsd_sequencer
  import rsd_pkg::*;
#(
  parameter logic [26:0] BLINK_CYC = RSD_BLINK_CYC,
  parameter logic [26:0] DWELL_CYC = RSD_DWELL_CYC
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [RSD_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read
  input  wire logic [RSD_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Asynchronous pins
  input  wire logic                  comm_wdt,
  input  wire logic                  ctrl_wdt,
  input  wire logic                  ovr_sw,
  // Display and interrupt
  output logic [31:0]                disp_text,
  output logic                       disp_blank,
  output logic                       irq
);

  function automatic logic [7:0] hx(input logic [3:0] v);
    hx = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction : hx
  function automatic logic [31:0] hx4(input logic [15:0] v);
    hx4 = {hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0])};
  endfunction : hx4
  // Restart step codes in run order; spare slots repeat the last code
  localparam logic [7:0] STEP_CODE [16] = '{8'h17, 8'h1b, 8'h21, 8'h25,
    8'h3e, 8'h59, 8'h5e, 8'h70, 8'h76, 8'h8e, 8'ha5, 8'hb4, 8'hfe, 8'hfe,
    8'hfe, 8'hfe};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] pin_s1, pin_s2, pin_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_d  <= 3'h0;
    end else begin
      pin_s1 <= {ovr_sw, ctrl_wdt, comm_wdt};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end
  logic comm_ev, ctrl_ev, ovr;
  assign comm_ev = pin_s2[0] & ~pin_d[0];
  assign ctrl_ev = pin_s2[1] & ~pin_d[1];
  assign ovr     = pin_s2[2];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; the bus master is the comms processor
  logic [RSD_ADDR_W-1:0] aw_a;
  logic                  aw_v, w_v;
  logic [31:0]           w_d;
  logic [3:0]            w_s;
  logic                  do_wr;
  logic [31:0]           cfg, code, ien, ist;
  assign awready = ~aw_v;
  assign wready  = ~w_v;
  assign arready = ~rvalid;
  assign do_wr   = aw_v & w_v & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v  <= 1'b0;
      w_v   <= 1'b0;
      aw_a  <= '0;
      w_d   <= 32'h0;
      w_s   <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      if (awvalid && !aw_v) begin
        aw_v <= 1'b1;
        aw_a <= awaddr;
      end
      if (wvalid && !w_v) begin
        w_v <= 1'b1;
        w_d <= wdata;
        w_s <= wstrb;
      end
      if (do_wr) begin
        aw_v   <= 1'b0;
        w_v    <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (aw_a[1:0] == 2'b00 && aw_a <= RSD_OFF_ICLR) ?
                  2'b00 : 2'b10;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] o);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = w_s[b] ? w_d[8*b +: 8] : o[8*b +: 8];
  endfunction : merge
  logic wr_cmd, wr_clr;
  assign wr_cmd = do_wr && aw_a == RSD_OFF_CMD && w_s[0];
  assign wr_clr = do_wr && aw_a == RSD_OFF_ICLR;
  // Display content is steered by bus writes from the comms side and by the control watchdog pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg  <= 32'h0;
      code <= {RSD_CTRL_NO_COMM, RSD_COMM_RAM_PAR};
      ien  <= 32'h0;
    end else begin
      if (do_wr && aw_a == RSD_OFF_CFG) cfg <= merge(cfg);
      if (do_wr && aw_a == RSD_OFF_CODE) code <= merge(code);
      if (do_wr && aw_a == RSD_OFF_IEN) ien <= merge(ien);
      // Watchdog code is applied last so a bus write cannot mask it
      if (ctrl_ev) code[31:16] <= RSD_CTRL_WDT;
    end
  end
  logic       detail;
  logic [3:0] filepos;
  logic [7:0] node;
  assign detail  = cfg[0];
  assign filepos = cfg[11:8];
  assign node    = cfg[23:16];
  logic swap_ev, fail_ev, take_ev;
  assign swap_ev = wr_cmd & w_d[RSD_CMD_SWAP];
  assign take_ev = wr_cmd & w_d[RSD_CMD_TAKE];
  assign fail_ev = (wr_cmd & w_d[RSD_CMD_FAIL]) | ctrl_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  rsd_state_t  state, next_state;
  logic [26:0] tmr, lim;
  logic        tick, blink;
  logic [3:0]  sidx;
  logic [2:0]  fidx;
  assign lim  = (state == RSD_FAIL && !detail) ? BLINK_CYC : DWELL_CYC;
  // Compare with >= so a mode change to a shorter interval cannot strand tmr
  assign tick = (tmr >= lim - 27'd1);
  always_comb begin
    next_state = state;
    if (fail_ev && state != RSD_FAIL) begin
      next_state = RSD_FAIL;
    end else begin
      unique case (state)
        RSD_BACKUP: if (swap_ev || take_ev) next_state = RSD_RUN;
        RSD_RUN:    if (swap_ev) next_state = RSD_SWAP;
        RSD_SWAP:   if (tick) next_state = RSD_STEP;
        RSD_STEP:   if (tick && sidx == RSD_STEP_LAST) next_state = RSD_SYNC;
        RSD_SYNC:   if (tick) next_state = RSD_BACKUP;
        RSD_FAIL:   next_state = RSD_FAIL;
        default:    next_state = RSD_BACKUP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= RSD_BACKUP;
      tmr   <= 27'h0;
    end else begin
      state <= next_state;
      tmr   <= (next_state != state || tick) ? 27'h0 : tmr + 27'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != RSD_STEP) begin
      sidx <= 4'h0;
    end else if (tick) begin
      sidx <= sidx + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || state != RSD_FAIL) begin
      fidx  <= 3'h0;
      blink <= 1'b0;
    end else if (tick && detail) begin
      fidx <= (fidx == RSD_FAIL_LAST) ? 3'h0 : fidx + 3'h1;
    end else if (tick) begin
      blink <= ~blink;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display text
  logic [31:0] next_text, fail_txt;
  assign fail_txt = {RSD_TXT_F, hx(filepos), hx(node[7:4]), hx(node[3:0])};

  always_comb begin
    unique case (state)
      RSD_RUN:  next_text = {RSD_TXT_OK, hx(node[7:4]), hx(node[3:0])};
      RSD_SWAP: next_text = RSD_TXT_SWAP;
      RSD_STEP: next_text = detail ? {RSD_TXT_TS, hx(STEP_CODE[sidx][7:4]),
                hx(STEP_CODE[sidx][3:0])} : RSD_TXT_SWAP;
      RSD_SYNC: next_text = RSD_TXT_SYNC;
      RSD_FAIL: begin
        if (!detail) begin
          next_text = blink ? RSD_TXT_BLANK : fail_txt;
        end else begin
          unique case (fidx)
            3'h0:    next_text = fail_txt;
            3'h1:    next_text = RSD_TXT_COMM;
            3'h2:    next_text = hx4(code[15:0]);
            3'h3:    next_text = RSD_TXT_CTRL;
            3'h4:    next_text = hx4(code[31:16]);
            default: next_text = RSD_TXT_BLANK;
          endcase
        end
      end
      default:  next_text = {RSD_TXT_BK, hx(node[7:4]), hx(node[3:0])};
    endcase
  end
  // Blanking is a held level so a dead comms processor cannot leave stale
  // text; the control watchdog is deliberately kept out of it
  logic wdt_lat, blank;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_lat <= 1'b0;
    end else if (comm_ev) begin
      wdt_lat <= 1'b1;
    end
  end
  assign blank = wdt_lat & ~ovr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_text  <= RSD_TXT_BLANK;
      disp_blank <= 1'b0;
    end else begin
      disp_text  <= blank ? RSD_TXT_BLANK : next_text;
      disp_blank <= blank;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and read path
  logic [3:0] ev;
  assign ev  = {ctrl_ev, comm_ev, next_state == RSD_FAIL && state != RSD_FAIL,
                state == RSD_SYNC && next_state == RSD_BACKUP};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist <= 32'h0;
    end else begin
      ist[3:0] <= (ist[3:0] & ~(wr_clr ? w_d[3:0] : 4'h0)) | ev;
    end
  end
  assign irq = |(ist[3:0] & ien[3:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= 2'b00;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rresp  <= 2'b00;
      unique case (araddr)
        RSD_OFF_CFG:  rdata <= cfg;
        RSD_OFF_CODE: rdata <= code;
        RSD_OFF_STAT: rdata <= {21'h0, fidx, sidx, wdt_lat, state};
        RSD_OFF_DISP: rdata <= disp_text;
        RSD_OFF_IST:  rdata <= ist;
        RSD_OFF_IEN:  rdata <= ien;
        RSD_OFF_CMD, RSD_OFF_ICLR: rdata <= 32'h0;
        default: begin
          rdata <= 32'h0;
          rresp <= 2'b10;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_swap_start: assert property (state == RSD_RUN && swap_ev && !fail_ev
    |=> state == RSD_SWAP and (!blank |=> disp_text == RSD_TXT_SWAP))
    else $error("swap banner missing");
  a_swap_take: assert property (state == RSD_BACKUP && swap_ev && !fail_ev
    |=> state == RSD_RUN)
    else $error("secondary not primary");
  a_step_end: assert property (state == RSD_STEP && tick &&
    sidx == RSD_STEP_LAST |=> state == RSD_SYNC)
    else $error("steps not followed by sync");
  a_nodetail_swap: assert property (state == RSD_STEP && !detail && !blank
    |=> disp_text == RSD_TXT_SWAP)
    else $error("step code shown in non-detailed");
  a_run_banner: assert property (state == RSD_RUN && !blank
    |=> disp_text[31:16] == RSD_TXT_OK)
    else $error("run banner wrong");
  a_fail_enter: assert property (fail_ev |=> state == RSD_FAIL)
    else $error("fail state not entered");
  a_fail_wrap: assert property (state == RSD_FAIL && detail && tick &&
    fidx == RSD_FAIL_LAST |=> fidx == 3'h0)
    else $error("detailed fail cycle wrong");
  a_wdt_blank: assert property (wdt_lat && !ovr
    |=> disp_text == RSD_TXT_BLANK && disp_blank)
    else $error("watchdog blanking missing");
  a_ovr_show: assert property (wdt_lat && ovr
    |=> !disp_blank && disp_text == $past(next_text))
    else $error("override ignored");
  a_ctrl_wdt: assert property (ctrl_ev && !wdt_lat |=> !disp_blank)
    else $error("control watchdog blanked");
  a_blink_rate: assert property (state == RSD_FAIL && !detail
    |-> tmr < BLINK_CYC)
    else $error("blink interval exceeded");
  a_wdt_hold: assert property (wdt_lat |=> wdt_lat)
    else $error("blanking released");
  a_dwell: assert property (state == RSD_SWAP && tmr != lim - 27'd1 &&
    !fail_ev |=> state == RSD_SWAP)
    else $error("dwell cut short");
  c_swap_done: cover property (state == RSD_SYNC ##1 state == RSD_BACKUP);
  c_fail_blink: cover property (state == RSD_FAIL && !detail && tick);
  c_fail_cycle: cover property (state == RSD_FAIL && fidx == RSD_FAIL_LAST);
  c_override: cover property (wdt_lat && ovr);

endmodule : rsd_sequencer
`default_nettype wire

// [test_redundant_status_display_sequencer.sv]
// Self-checking bench for the status display sequencer
`timescale 1ns/10ps
`default_nettype none
module test_redundant_status_display_sequencer;
  import rsd_pkg::*;
  localparam logic [26:0] BLINK = 27'h8;
  localparam logic [26:0] DWELL = 27'h4;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        disp_blank, comm_wdt, ctrl_wdt, ovr_sw;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, disp_text, shown;
  logic        req_comm = 1'b0, req_ctrl = 1'b0, req_sw = 1'b0;
  logic [15:0] changes;
  logic [7:0]  steps [13] = '{8'h17, 8'h1b, 8'h21, 8'h25, 8'h3e, 8'h59,
                              8'h5e, 8'h70, 8'h76, 8'h8e, 8'ha5, 8'hb4, 8'hfe};
  int          mismatches = 0, samples_checked = 0, seed = 32'h83bf410e;
  rsd_sequencer #(.BLINK_CYC(BLINK), .DWELL_CYC(DWELL)) i_rsd_sequencer (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .comm_wdt, .ctrl_wdt, .ovr_sw, .disp_text,
    .disp_blank, .irq);
  rsd_panel_model i_rsd_panel_model (
    .aclk, .aresetn, .req_comm, .req_ctrl, .req_sw, .disp_text, .disp_blank,
    .comm_wdt, .ctrl_wdt, .ovr_sw, .shown, .changes);
  always #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // Waits on handshakes rely on the watchdog to end a hang
  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  // Counts cycles until the glass shows exp, at most lim
  task automatic see(string nm, logic [31:0] exp, int lim, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (shown !== exp && n < lim);
    check(nm, shown, exp);
  endtask : see
  function automatic logic [7:0] hx(logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : hx
  function automatic logic [31:0] hx4(logic [15:0] v);
    return {hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0])};
  endfunction : hx4
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, ok, bk, fb;
    logic [31:0] fl [7];
    logic [1:0]  r;
    logic [7:0]  node;
    logic [15:0] cc, c0;
    int          n;
    node = 8'($random(seed));
    cc = 16'($random(seed));
    ok = {RSD_TXT_OK, hx(node[7:4]), hx(node[3:0])};
    bk = {RSD_TXT_BK, hx(node[7:4]), hx(node[3:0])};
    fb = {RSD_TXT_F, hx(4'h1), hx(node[7:4]), hx(node[3:0])};
    fl = '{fb, RSD_TXT_COMM, hx4(cc), RSD_TXT_CTRL, hx4(RSD_CTRL_NO_COMM),
           RSD_TXT_BLANK, fb};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RSD_OFF_CODE, d, r);
    check("code_rst", d, {RSD_CTRL_NO_COMM, RSD_COMM_RAM_PAR});
    rd(8'h20, d, r);
    check("rd_unmapped", r, 2'b10);
    wr(8'h24, 32'h1, r);
    check("wr_unmapped", r, 2'b10);
    wr(RSD_OFF_CFG, {8'h00, node, 8'h01, 8'h01}, r);
    see("backup", bk, 8, n);
    wr(RSD_OFF_CMD, 32'h4, r);
    see("takeover", ok, 8, n);
    check("run_now", n, 1);
    // The panel counts a change one edge late; let the takeover land first
    @(negedge aclk);
    c0 = changes;
    repeat (40) @(negedge aclk);
    check("run_steady", changes - c0, 0);
    wr(RSD_OFF_IEN, 32'h1, r);
    wr(RSD_OFF_CMD, 32'h1, r);
    see("swap", RSD_TXT_SWAP, 8, n);
    foreach (steps[i]) begin
      see("step", {RSD_TXT_TS, hx(steps[i][7:4]), hx(steps[i][3:0])}, 12, n);
      check("dwell", n, DWELL);
    end
    see("sync", RSD_TXT_SYNC, 12, n);
    see("swap_end", bk, 12, n);
    check("irq_done", irq, 1'b1);
    wr(RSD_OFF_ICLR, 32'h1, r);
    check("irq_clr", irq, 1'b0);
    wr(RSD_OFF_IEN, 32'h0, r);
    wr(RSD_OFF_CFG, {8'h00, node, 8'h01, 8'h00}, r);
    wr(RSD_OFF_CMD, 32'h1, r);
    see("run_again", ok, 8, n);
    wr(RSD_OFF_CMD, 32'h1, r);
    see("swap_nd", RSD_TXT_SWAP, 8, n);
    c0 = changes;
    see("sync_nd", RSD_TXT_SYNC, 100, n);
    check("swap_hold", n, 14 * DWELL);
    check("no_steps", changes - c0, 1);
    see("backup_nd", bk, 12, n);
    wr(RSD_OFF_CODE, {RSD_CTRL_NO_COMM, cc}, r);
    wr(RSD_OFF_CFG, {8'h00, node, 8'h01, 8'h01}, r);
    wr(RSD_OFF_CMD, 32'h2, r);
    foreach (fl[i]) see("fail_seq", fl[i], 12, n);
    rd(RSD_OFF_IST, d, r);
    check("ist_fail", d[1], 1'b1);
    check("irq_mask", irq, 1'b0);
    wr(RSD_OFF_CFG, {8'h00, node, 8'h01, 8'h00}, r);
    see("blink_on", fb, 60, n);
    // First blank depends on where the detailed cycle stood; time later ones
    see("blink_off", RSD_TXT_BLANK, 20, n);
    see("blink_on2", fb, 20, n);
    check("blink_on_t", n, BLINK);
    see("blink_off2", RSD_TXT_BLANK, 20, n);
    check("blink_off_t", n, BLINK);
    req_ctrl <= 1'b1;
    repeat (3) @(posedge aclk);
    req_ctrl <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(RSD_OFF_CODE, d, r);
    check("ctrl_code", d[31:16], RSD_CTRL_WDT);
    check("ctrl_noblank", disp_blank, 1'b0);
    req_comm <= 1'b1;
    repeat (3) @(posedge aclk);
    req_comm <= 1'b0;
    repeat (20) @(posedge aclk);
    check("comm_blank", disp_blank, 1'b1);
    req_sw <= 1'b1;
    repeat (6) @(posedge aclk);
    check("override", disp_blank, 1'b0);
    req_sw <= 1'b0;
    repeat (6) @(posedge aclk);
    check("reblank", disp_blank, 1'b1);
    rd(RSD_OFF_IST, d, r);
    check("ist_wdt", d[3:2], 2'b11);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RSD_OFF_STAT, d, r);
    check("stat_rst", d[3:0], 4'h0);
    check("blank_rst", disp_blank, 1'b0);
    results();
  end
  // Whole run is under 1,000 cycles; this bound is over twenty times that
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results();
  end
endmodule : test_redundant_status_display_sequencer
`default_nettype wire
